// ==== rtl/latchoff_and_phase_config.sv ====
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module latchoff_and_phase_config (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic [31:0]                        wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          fuse_ov_latch_en,
  input  wire logic                          fuse_sc_latch_en,
  input  wire logic                          fuse_half_rate_ch1,
  input  wire logic                          fuse_half_rate_ch3,
  input  wire latchoff_phase_pkg::fault_in_t fault,
  output logic [3:0]                         channel_latched_flag,
  output logic [3:0]                         sw_clk,
  output logic                               irq
);

  latchoff_phase_pkg::latchoff_cfg_t   lch_q;
  latchoff_phase_pkg::latchoff_cfg_t   lch_d;
  latchoff_phase_pkg::freq_phase_cfg_t swc_q;
  latchoff_phase_pkg::freq_phase_cfg_t swc_d;
  logic [3:0]  stat_q;
  logic [3:0]  stat_d;
  logic [3:0]  mask_q;
  logic [3:0]  mask_d;
  logic [7:0]  div_q;
  logic [7:0]  div_d;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic        fuse_pend_q;
  logic        fuse_pend_d;
  logic [3:0]  latch_evt;
  logic [5:0]  word_idx;
  logic        wr;
  logic        rd;

  assign word_idx = wb_adr_i[7:latchoff_phase_pkg::BYTE_SHIFT];
  assign wr = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i;

  // Per-channel latch events, gated by each enable bit
  genvar ch;
  generate
    for (ch = 0; ch < latchoff_phase_pkg::NCH; ch++) begin : g_ch
      assign latch_evt[ch] =
        (fault.overvolt[ch] && lch_q.ov_en[ch]) ||
        (fault.short_circ[ch] && lch_q.sc_en[ch]);
    end
  endgenerate

  always_comb begin
    lch_d       = lch_q;
    swc_d       = swc_q;
    mask_d      = mask_q;
    div_d       = div_q;
    fuse_pend_d = 1'b0;
    stat_d      = stat_q;
    // Fuse straps are sampled in the first cycle after reset release
    if (fuse_pend_q) begin
      lch_d.ov_en         = {4{fuse_ov_latch_en}};
      lch_d.sc_en         = {4{fuse_sc_latch_en}};
      swc_d.half_rate_ch1 = fuse_half_rate_ch1;
      swc_d.half_rate_ch3 = fuse_half_rate_ch3;
    end
    if (wr) begin
      if (word_idx == latchoff_phase_pkg::IDX_LATCHOFF_EN[5:0]) begin
        lch_d = wb_dat_i[7:0];
      end else if (word_idx == latchoff_phase_pkg::IDX_FREQ_PHASE[5:0]) begin
        swc_d = wb_dat_i[7:0];
      end else if (word_idx == latchoff_phase_pkg::IDX_LATCH_STATUS[5:0]) begin
        stat_d = stat_q & ~wb_dat_i[3:0];
      end else if (word_idx == latchoff_phase_pkg::IDX_IRQ_MASK[5:0]) begin
        mask_d = wb_dat_i[3:0];
      end else if (word_idx == latchoff_phase_pkg::IDX_PERIOD_DIV[5:0]) begin
        div_d = wb_dat_i[7:0];
      end
    end
    // Set wins over a simultaneous write-one-to-clear
    stat_d = stat_d | latch_evt;
  end

  always_comb begin
    ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = 32'h0000_0000;
    if (rd) begin
      if (word_idx == latchoff_phase_pkg::IDX_LATCHOFF_EN[5:0]) begin
        rdat_d[7:0] = lch_q;
      end else if (word_idx == latchoff_phase_pkg::IDX_FREQ_PHASE[5:0]) begin
        rdat_d[7:0] = swc_q;
      end else if (word_idx == latchoff_phase_pkg::IDX_LATCH_STATUS[5:0]) begin
        rdat_d[3:0] = stat_q;
      end else if (word_idx == latchoff_phase_pkg::IDX_IRQ_MASK[5:0]) begin
        rdat_d[3:0] = mask_q;
      end else if (word_idx == latchoff_phase_pkg::IDX_PERIOD_DIV[5:0]) begin
        rdat_d[7:0] = div_q;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lch_q       <= 8'h00;
      swc_q       <= {2'h0, latchoff_phase_pkg::PHASE_CH4_RST,
                      latchoff_phase_pkg::PHASE_CH3_RST,
                      latchoff_phase_pkg::PHASE_CH2_RST};
      stat_q      <= 4'h0;
      mask_q      <= 4'h0;
      div_q       <= latchoff_phase_pkg::PERIOD_DIV_RST;
      ack_q       <= 1'b0;
      rdat_q      <= 32'h0000_0000;
      fuse_pend_q <= 1'b1;
    end else begin
      lch_q       <= lch_d;
      swc_q       <= swc_d;
      stat_q      <= stat_d;
      mask_q      <= mask_d;
      div_q       <= div_d;
      ack_q       <= ack_d;
      rdat_q      <= rdat_d;
      fuse_pend_q <= fuse_pend_d;
    end
  end

  assign wb_ack_o             = ack_q;
  assign wb_dat_o             = rdat_q;
  assign channel_latched_flag = stat_q;
  assign irq                  = |(stat_q & mask_q);

  phase_clock_gen u_phase (
    .clk        (clk),
    .nrst       (nrst),
    .period_div (div_q),
    .cfg        (swc_q),
    .sw_clk     (sw_clk)
  );

endmodule : latchoff_and_phase_config
`default_nettype wire

// ==== rtl/latchoff_phase_pkg.sv ====
package latchoff_phase_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_LATCHOFF_EN  = 8'h07;
  localparam logic [7:0] IDX_FREQ_PHASE   = 8'h08;
  localparam logic [7:0] IDX_LATCH_STATUS = 8'h0c;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h10;
  localparam logic [7:0] IDX_PERIOD_DIV   = 8'h11;

  localparam logic [1:0] BYTE_SHIFT = 2'h2;

  // Field positions
  localparam int OV_LSB      = 4;
  localparam int SC_LSB      = 0;
  localparam int HALF3_BIT   = 7;
  localparam int HALF1_BIT   = 6;
  localparam int PH4_LSB     = 4;
  localparam int PH3_LSB     = 2;
  localparam int PH2_LSB     = 0;

  localparam logic [1:0] PHASE_CH4_RST = 2'h2;
  localparam logic [1:0] PHASE_CH3_RST = 2'h0;
  localparam logic [1:0] PHASE_CH2_RST = 2'h2;

  localparam int NCH = 4;

  // Master period in clk cycles is 4*(div+1); default 4*(24+1)=100 cycles
  localparam logic [7:0] PERIOD_DIV_RST = 8'h18;

  typedef struct packed {
    logic [3:0] ov_en;
    logic [3:0] sc_en;
  } latchoff_cfg_t;

  typedef struct packed {
    logic       half_rate_ch3;
    logic       half_rate_ch1;
    logic [1:0] phase_offset_ch4;
    logic [1:0] phase_offset_ch3;
    logic [1:0] phase_offset_ch2;
  } freq_phase_cfg_t;

  typedef struct packed {
    logic [3:0] overvolt;
    logic [3:0] short_circ;
  } fault_in_t;

endpackage : latchoff_phase_pkg

// ==== rtl/phase_clock_gen.sv ====
`timescale 1ns/10ps
`default_nettype none
// Channel switching clocks derived from one master phase counter.
module phase_clock_gen (
  input  wire logic                                clk,
  input  wire logic                                nrst,
  input  wire logic [7:0]                          period_div,
  input  wire latchoff_phase_pkg::freq_phase_cfg_t cfg,
  output logic [3:0]                               sw_clk
);

  logic [7:0] quarter_cnt_q;
  logic [7:0] quarter_cnt_d;
  logic [1:0] quad_q;
  logic [1:0] quad_d;
  logic [1:0] half_q;
  logic [1:0] half_d;
  logic [3:0] sw_clk_d;
  logic [1:0] quad_ch1;
  logic [1:0] quad_ch2;
  logic [1:0] quad_ch3;
  logic [1:0] quad_ch4;

  // Each step of quad is one quarter master period
  always_comb begin
    quarter_cnt_d = quarter_cnt_q + 8'h01;
    quad_d        = quad_q;
    half_d        = half_q;
    if (quarter_cnt_q >= period_div) begin
      quarter_cnt_d = 8'h00;
      quad_d        = quad_q + 2'h1;
      if (quad_q == 2'h3) begin
        half_d = ~half_q;
      end
    end
  end

  // Channel 1 is the zero reference; channels 2 and 4, and 3 at full rate, lag by their offset
  always_comb begin
    quad_ch1 = quad_q;
    quad_ch2 = quad_q - cfg.phase_offset_ch2;
    quad_ch3 = quad_q - cfg.phase_offset_ch3;
    quad_ch4 = quad_q - cfg.phase_offset_ch4;
    sw_clk_d[0] = cfg.half_rate_ch1 ? half_q[0] : ~quad_ch1[1];
    sw_clk_d[1] = ~quad_ch2[1];
    sw_clk_d[2] = cfg.half_rate_ch3 ? half_q[1] : ~quad_ch3[1];
    sw_clk_d[3] = ~quad_ch4[1];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quarter_cnt_q <= 8'h00;
      quad_q        <= 2'h0;
      half_q        <= 2'h0;
      sw_clk        <= 4'h0;
    end else begin
      quarter_cnt_q <= quarter_cnt_d;
      quad_q        <= quad_d;
      half_q        <= half_d;
      sw_clk        <= sw_clk_d;
    end
  end

endmodule : phase_clock_gen
`default_nettype wire

// ==== verification/latchoff_and_phase_config_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module latchoff_and_phase_config_asserts (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  channel_latched_flag,
  input wire logic        irq,
  input wire latchoff_phase_pkg::fault_in_t fault
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire rq = wb_cyc_i && wb_stb_i;
  property p_ack_take; rq && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_take: assert property (p_ack_take) else $error("ack late");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held");
  property p_ack_src; wb_ack_o |-> $past(rq && !wb_ack_o); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack unasked");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data idle");
  property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("data upper");
  // A flag may only rise on a fault seen at the edge before
  property p_flag_src; (channel_latched_flag & ~$past(channel_latched_flag)
    & ~$past(fault.overvolt | fault.short_circ)) == 4'h0; endproperty
  a_flag_src: assert property (p_flag_src) else $error("flag cause");
  property p_flag_hold; |($past(channel_latched_flag) & ~channel_latched_flag)
    |-> $past(rq && wb_we_i); endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_irq_fall; $fell(irq) |-> $past(rq && wb_we_i); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
  c_write: cover property (rq && wb_we_i && wb_ack_o);
  c_irq: cover property ($rose(irq));
  c_clear: cover property ($fell(|channel_latched_flag));
endmodule : latchoff_and_phase_config_asserts
bind latchoff_and_phase_config latchoff_and_phase_config_asserts u_chk (
  .clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
  .channel_latched_flag, .irq, .fault);
`default_nettype wire

// ==== verification/tb_latchoff_and_phase_config.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_latchoff_and_phase_config;
  logic        clk = '0, nrst = '0, cs = '0, we = '0, ack, irq;
  logic [7:0]  adr = '0, flt = '0;
  logic [3:0]  sel = '0, fz, flag, swc, prev = '0;
  logic [31:0] dat = '0, rdat;
  int          seed = 32'hee84, n_errors = 0, n_checks = 0, cnt = 0;
  int          rise[4], prise[4], i, k, m, en;
  always #5 clk = ~clk;
  latchoff_and_phase_config dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cs),
    .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
    .fuse_ov_latch_en(fz[0]), .fuse_sc_latch_en(fz[1]),
    .fuse_half_rate_ch1(fz[2]), .fuse_half_rate_ch3(fz[3]),
    .fault(flt), .channel_latched_flag(flag), .sw_clk(swc));
  task close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task chk(input logic [31:0] g, e);
    n_checks++;
    n_errors += int'(g !== e);
    if (g !== e) $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
  endtask : chk
  task wb(input logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s,
          logic [31:0] e);
    @(posedge clk);
    cs <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    if (!w) chk(rdat, e);
    cs <= 1'h0;
  endtask : wb
  // Rise times of each switching clock, for phase and period checks
  always @(posedge clk) begin
    cnt++;
    for (int j = 0; j < 4; j++)
      if (swc[j] && !prev[j]) begin
        prise[j] = rise[j];
        rise[j] = cnt;
      end
    prev <= swc;
    n_errors += int'(cnt == 5000);
    if (cnt == 5000) close_out();
  end
  initial begin
    fz <= 4'($random(seed));
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    wb(1'h0, 8'h1c, '0, 4'hf, {24'h0, {4{fz[0]}}, {4{fz[1]}}});
    wb(1'h0, 8'h20, '0, 4'hf, {24'h0, fz[3:2], 6'h22});
    for (i = 0; i < 6; i++) begin
      k = 28 + 4 * (i % 2);
      en = $random(seed);
      wb(1'h1, 8'(k), en, 4'hf, '0);
      wb(1'h1, 8'(k), ~en, 4'he, '0);
      wb(1'h0, 8'(k), '0, 4'hf, {24'h0, en[7:0]});
      wb(1'h0, 8'h3c, '0, 4'hf, '0);
    end
    for (i = 0; i < 8; i++) begin
      en = $random(seed);
      wb(1'h1, 8'h1c, en, 4'hf, '0);
      wb(1'h1, 8'h40, en >> 8, 4'hf, '0);
      wb(1'h0, 8'h40, '0, 4'hf, {28'h0, en[11:8]});
      flt <= en[23:16];
      @(posedge clk);
      flt <= '0;
      @(posedge clk);
      m = m | (en[23:20] & en[7:4]) | (en[19:16] & en[3:0]);
      chk(32'(flag), m);
      chk(32'(irq), 32'((m & en[11:8]) != 0));
      wb(1'h1, 8'h30, en >> 24, 4'hf, '0);
      m = m & ~en[27:24];
      wb(1'h0, 8'h30, '0, 4'hf, m);
    end
    wb(1'h1, 8'h44, 32'h3, 4'hf, '0);
    wb(1'h0, 8'h44, '0, 4'hf, 32'h3);
    for (k = 0; k < 4; k++) begin
      wb(1'h1, 8'h20, k * 21, 4'hf, '0);
      repeat (50) @(posedge clk);
      chk(rise[0] - prise[0], 32'h10);
      for (i = 1; i < 4; i++)
        chk((rise[i] - rise[0] + 32) % 16, k * 4);
    end
    wb(1'h1, 8'h20, 32'hc0, 4'hf, '0);
    repeat (120) @(posedge clk);
    chk(rise[0] - prise[0], 32);
    chk(rise[2] - prise[2], 32);
    close_out();
  end
endmodule : tb_latchoff_and_phase_config
`default_nettype wire
